// ==== rtl/qcsp_top.v ====
// quadrature counting on channels 1/2, reset-synchronized pwm on 3/4
`timescale 1ns/1ps
`include "qcsp_defs.vh"
module qcsp_top (
  input wire core_clk,
  input wire rstn,
  input wire [3:0] ch1_mode,
  input wire [3:0] ch2_mode,
  input wire [3:0] ch3_mode,
  input wire ch1_start,
  input wire ch2_start,
  input wire ch3_start,
  input wire ch4_start,
  input wire [1:0] ch1_clear_sel,
  input wire [1:0] ch2_clear_sel,
  input wire [15:0] ch1_gra,
  input wire [15:0] ch1_grb,
  input wire [15:0] ch2_gra,
  input wire [15:0] ch2_grb,
  input wire ch1_capture,
  input wire ch2_capture,
  input wire ch1_flag_clear,
  input wire ch2_flag_clear,
  input wire cnt_load,
  input wire [15:0] cnt_load_value,
  input wire [15:0] ch3_period_reg,
  input wire [15:0] ch3_transition_reg,
  input wire [15:0] ch4_transition_reg_a,
  input wire [15:0] ch4_transition_reg_b,
  input wire ext_clock_in_a,
  input wire ext_clock_in_b,
  input wire ext_clock_in_c,
  input wire ext_clock_in_d,
  output reg [15:0] ch1_count,
  output reg [15:0] ch2_count,
  output reg [15:0] ch3_counter,
  output reg [15:0] ch4_counter,
  output reg [15:0] ch1_capture_value,
  output reg [15:0] ch2_capture_value,
  output reg ch1_overflow_flag,
  output reg ch1_underflow_flag,
  output reg ch1_count_direction_flag,
  output reg ch2_overflow_flag,
  output reg ch2_underflow_flag,
  output reg ch2_count_direction_flag,
  output reg ch1_match_a,
  output reg ch1_match_b,
  output reg ch2_match_a,
  output reg ch2_match_b,
  output reg pwm_out1_pos,
  output reg pwm_out1_neg,
  output reg pwm_out2_pos,
  output reg pwm_out2_neg,
  output reg pwm_out3_pos,
  output reg pwm_out3_neg
);
  // ==========================================
  // reset release through two flops
  reg rst_s1_reg, rst_n_reg;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // ==========================================
  // mode decode helpers
  function is_phase;
    input [3:0] m;
    begin
      is_phase = (m == `QCSP_MODE_PHASE1) || (m == `QCSP_MODE_PHASE2) ||
                 (m == `QCSP_MODE_PHASE3) || (m == `QCSP_MODE_PHASE4);
    end
  endfunction

  function clr_hit;
    input [1:0] sel;
    input ma;
    input mb;
    begin
      clr_hit = ((sel == `QCSP_CLR_GRA) & ma) | ((sel == `QCSP_CLR_GRB) & mb);
    end
  endfunction

  // ==========================================
  // phase decoders, only channels 1 and 2 have them
  wire c1_up, c1_dn, c2_up, c2_dn;
  qcsp_phase_dec u_dec1 (
    .core_clk(core_clk),
    .rst_n(rst_n_reg),
    .mode(ch1_mode),
    .phase_a(ext_clock_in_a),
    .phase_b(ext_clock_in_b),
    .step_up(c1_up),
    .step_dn(c1_dn)
  );
  qcsp_phase_dec u_dec2 (
    .core_clk(core_clk),
    .rst_n(rst_n_reg),
    .mode(ch2_mode),
    .phase_a(ext_clock_in_c),
    .phase_b(ext_clock_in_d),
    .step_up(c2_up),
    .step_dn(c2_dn)
  );

  // steps only count in phase mode with the channel started
  wire c1_run = is_phase(ch1_mode) & ch1_start;
  wire c2_run = is_phase(ch2_mode) & ch2_start;
  wire u1 = c1_run & c1_up;
  wire d1 = c1_run & c1_dn;
  wire u2 = c2_run & c2_up;
  wire d2 = c2_run & c2_dn;
  wire m1a = ch1_count == ch1_gra;
  wire m1b = ch1_count == ch1_grb;
  wire m2a = ch2_count == ch2_gra;
  wire m2b = ch2_count == ch2_grb;

  // ==========================================
  // channel 1 and 2 up/down counters with clear, compare and capture
  always @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ch1_count <= `QCSP_CNT_ZERO;
      ch2_count <= `QCSP_CNT_ZERO;
      ch1_match_a <= 1'b0;
      ch1_match_b <= 1'b0;
      ch2_match_a <= 1'b0;
      ch2_match_b <= 1'b0;
      ch1_capture_value <= `QCSP_CNT_ZERO;
      ch2_capture_value <= `QCSP_CNT_ZERO;
    end else begin
      ch1_match_a <= m1a & c1_run;
      ch1_match_b <= m1b & c1_run;
      ch2_match_a <= m2a & c2_run;
      ch2_match_b <= m2b & c2_run;
      if (ch1_capture)
        ch1_capture_value <= ch1_count;
      if (ch2_capture)
        ch2_capture_value <= ch2_count;
      if (cnt_load && !ch1_start)
        ch1_count <= cnt_load_value;
      else if (c1_run && clr_hit(ch1_clear_sel, m1a, m1b))
        ch1_count <= `QCSP_CNT_ZERO;
      else if (u1)
        ch1_count <= ch1_count + `QCSP_CNT_ONE;
      else if (d1)
        ch1_count <= ch1_count - `QCSP_CNT_ONE;
      if (cnt_load && !ch2_start)
        ch2_count <= cnt_load_value;
      else if (c2_run && clr_hit(ch2_clear_sel, m2a, m2b))
        ch2_count <= `QCSP_CNT_ZERO;
      else if (u2)
        ch2_count <= ch2_count + `QCSP_CNT_ONE;
      else if (d2)
        ch2_count <= ch2_count - `QCSP_CNT_ONE;
    end
  end

  // ==========================================
  // status flags, a set beats a clear in the same cycle
  always @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ch1_overflow_flag <= 1'b0;
      ch1_underflow_flag <= 1'b0;
      ch1_count_direction_flag <= 1'b0;
      ch2_overflow_flag <= 1'b0;
      ch2_underflow_flag <= 1'b0;
      ch2_count_direction_flag <= 1'b0;
    end else begin
      if (u1 && ch1_count == `QCSP_CNT_MAX)
        ch1_overflow_flag <= 1'b1;
      else if (ch1_flag_clear)
        ch1_overflow_flag <= 1'b0;
      if (d1 && ch1_count == `QCSP_CNT_ZERO)
        ch1_underflow_flag <= 1'b1;
      else if (ch1_flag_clear)
        ch1_underflow_flag <= 1'b0;
      if (u1)
        ch1_count_direction_flag <= 1'b1;
      else if (d1)
        ch1_count_direction_flag <= 1'b0;
      if (u2 && ch2_count == `QCSP_CNT_MAX)
        ch2_overflow_flag <= 1'b1;
      else if (ch2_flag_clear)
        ch2_overflow_flag <= 1'b0;
      if (d2 && ch2_count == `QCSP_CNT_ZERO)
        ch2_underflow_flag <= 1'b1;
      else if (ch2_flag_clear)
        ch2_underflow_flag <= 1'b0;
      if (u2)
        ch2_count_direction_flag <= 1'b1;
      else if (d2)
        ch2_count_direction_flag <= 1'b0;
    end
  end

  // ==========================================
  // reset-synchronized pwm on channels 3 and 4
  wire rs_mode = ch3_mode == `QCSP_MODE_RSPWM;
  wire rs_run = rs_mode & ch3_start;
  wire period_hit = ch3_counter == ch3_period_reg;
  wire t1_hit = ch3_counter == ch3_transition_reg;
  wire t2_hit = ch3_counter == ch4_transition_reg_a;
  wire t3_hit = ch3_counter == ch4_transition_reg_b;

  // counters: ch3 counts up, clears on period; ch4 follows when started
  always @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ch3_counter <= `QCSP_CNT_ZERO;
      ch4_counter <= `QCSP_CNT_ZERO;
    end else if (cnt_load && !ch3_start && !ch4_start) begin
      ch3_counter <= cnt_load_value;
      ch4_counter <= cnt_load_value;
    end else if (rs_run) begin
      if (period_hit)
        ch3_counter <= `QCSP_CNT_ZERO;
      else
        ch3_counter <= ch3_counter + `QCSP_CNT_ONE;
      if (ch4_start) begin
        if (period_hit)
          ch4_counter <= `QCSP_CNT_ZERO;
        else
          ch4_counter <= ch4_counter + `QCSP_CNT_ONE;
      end
    end
  end

  // outputs toggle on own match and on counter clear, inverse follows in rs mode, all six low outside it
  reg o1_reg, o2_reg, o3_reg;
  always @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o1_reg <= 1'b0;
      o2_reg <= 1'b0;
      o3_reg <= 1'b0;
      pwm_out1_pos <= 1'b0;
      pwm_out1_neg <= 1'b0;
      pwm_out2_pos <= 1'b0;
      pwm_out2_neg <= 1'b0;
      pwm_out3_pos <= 1'b0;
      pwm_out3_neg <= 1'b0;
    end else begin
      if (rs_run) begin
        if (t1_hit ^ period_hit)
          o1_reg <= ~o1_reg;
        if (t2_hit ^ period_hit)
          o2_reg <= ~o2_reg;
        if (t3_hit ^ period_hit)
          o3_reg <= ~o3_reg;
      end
      pwm_out1_pos <= rs_mode & o1_reg;
      pwm_out1_neg <= rs_mode & ~o1_reg;
      pwm_out2_pos <= rs_mode & o2_reg;
      pwm_out2_neg <= rs_mode & ~o2_reg;
      pwm_out3_pos <= rs_mode & o3_reg;
      pwm_out3_neg <= rs_mode & ~o3_reg;
    end
  end
endmodule

// ==== pkg/qcsp_defs.vh ====
// constants for the quadrature count and reset-synchronized pwm block
`ifndef QCSP_DEFS_VH
`define QCSP_DEFS_VH
`define QCSP_CNT_W 16
`define QCSP_CNT_ZERO 16'h0000
`define QCSP_CNT_MAX 16'hFFFF
`define QCSP_CNT_ONE 16'h0001
`define QCSP_MODE_W 4
`define QCSP_MODE_NORMAL 4'h0
`define QCSP_MODE_PHASE1 4'h4
`define QCSP_MODE_PHASE2 4'h5
`define QCSP_MODE_PHASE3 4'h6
`define QCSP_MODE_PHASE4 4'h7
`define QCSP_MODE_RSPWM 4'h8
`define QCSP_CLR_W 2
`define QCSP_CLR_NONE 2'h0
`define QCSP_CLR_GRA 2'h1
`define QCSP_CLR_GRB 2'h2
`endif

// ==== rtl/qcsp_phase_dec.v ====
// quadrature phase decoder: sample, edge detect, count step
`timescale 1ns/1ps
`include "qcsp_defs.vh"
module qcsp_phase_dec (
  input wire core_clk,
  input wire rst_n,
  input wire [3:0] mode,
  input wire phase_a,
  input wire phase_b,
  output reg step_up,
  output reg step_dn
);
  // ==========================================
  // input synchronisers and previous samples
  reg a_s1_reg, a_s2_reg, a_d_reg;
  reg b_s1_reg, b_s2_reg, b_d_reg;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_s1_reg <= 1'b0;
      a_s2_reg <= 1'b0;
      a_d_reg <= 1'b0;
      b_s1_reg <= 1'b0;
      b_s2_reg <= 1'b0;
      b_d_reg <= 1'b0;
    end else begin
      a_s1_reg <= phase_a;
      a_s2_reg <= a_s1_reg;
      a_d_reg <= a_s2_reg;
      b_s1_reg <= phase_b;
      b_s2_reg <= b_s1_reg;
      b_d_reg <= b_s2_reg;
    end
  end
  // ==========================================
  // edge and level decode per variant
  wire a_r = a_s2_reg & ~a_d_reg;
  wire a_f = ~a_s2_reg & a_d_reg;
  wire b_r = b_s2_reg & ~b_d_reg;
  wire b_f = ~b_s2_reg & b_d_reg;
  wire a_h = a_s2_reg;
  wire b_h = b_s2_reg;
  reg up_c, dn_c;
  always @* begin
    up_c = 1'b0;
    dn_c = 1'b0;
    case (mode)
      `QCSP_MODE_PHASE1: begin
        up_c = (b_r & a_h) | (b_f & ~a_h) |
               (a_r & ~b_h) | (a_f & b_h);
        dn_c = (b_f & a_h) | (b_r & ~a_h) | (a_r & b_h) | (a_f & ~b_h);
      end
      `QCSP_MODE_PHASE2: begin
        up_c = a_f & b_h;
        dn_c = a_f & ~b_h;
      end
      `QCSP_MODE_PHASE3: begin
        up_c = a_f & b_h;
        dn_c = b_f & a_h;
      end
      `QCSP_MODE_PHASE4: begin
        up_c = (b_r & a_h) | (b_f & ~a_h);
        dn_c = (b_f & a_h) | (b_r & ~a_h);
      end
      default: begin
        up_c = 1'b0;
        dn_c = 1'b0;
      end
    endcase
  end
  // one step per clock at most
  always @* begin
    step_up = up_c & ~dn_c;
    step_dn = dn_c & ~up_c;
  end
endmodule

// ==== verification/qcsp_assertions.sv ====
// port checker for the quadrature count and pwm block
`timescale 1ns/1ps
module qcsp_checker (
  input wire core_clk,
  input wire rstn,
  input wire [3:0] ch1_mode,
  input wire [3:0] ch3_mode,
  input wire ch1_start,
  input wire ch3_start,
  input wire cnt_load,
  input wire ext_clock_in_a,
  input wire ext_clock_in_b,
  input wire [15:0] ch3_period_reg,
  input wire [15:0] ch1_count,
  input wire [15:0] ch3_counter,
  input wire ch1_overflow_flag,
  input wire ch1_underflow_flag,
  input wire ch1_count_direction_flag,
  input wire pwm_out1_pos,
  input wire pwm_out1_neg,
  input wire pwm_out2_pos,
  input wire pwm_out2_neg,
  input wire pwm_out3_pos,
  input wire pwm_out3_neg
);
  // =====
  // counting and pwm relations
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_step_latency: assert property (
    ch1_start && ch1_mode == 4'h4 && $rose(ext_clock_in_b) && ext_clock_in_a
    |-> ##2 ch1_count == $past(ch1_count, 2)
    ##2 ch1_count == $past(ch1_count, 4) + 16'h0001)
    else $error("phase step not applied three edges later");
  a_overflow_set: assert property (
    ch1_start && ch1_count == 16'hFFFF ##1 ch1_count == 16'h0000
    |-> ##[0:1] ch1_overflow_flag) else $error("overflow flag missing");
  a_underflow_set: assert property (
    ch1_start && ch1_count == 16'h0000 ##1 ch1_count == 16'hFFFF
    |-> ##[0:1] ch1_underflow_flag) else $error("underflow flag missing");
  a_dir_up: assert property (
    ch1_start && !$past(cnt_load) &&
    ch1_count == $past(ch1_count) + 16'h0001
    |-> ##[0:1] ch1_count_direction_flag) else $error("direction not up");
  a_halt_hold: assert property (
    (!ch1_start && !cnt_load) [*2] |=> $stable(ch1_count))
    else $error("halted counter moved");
  a_pwm_clear: assert property (
    ch3_mode == 4'h8 && ch3_start && ch3_counter == ch3_period_reg
    |=> ch3_counter == 16'h0000) else $error("no clear on period");
  a_pwm_upcount: assert property (
    ch3_mode == 4'h8 && ch3_start && ch3_counter != ch3_period_reg
    |=> ch3_counter == $past(ch3_counter) + 16'h0001)
    else $error("pwm counter not counting up");
  a_pwm_pairs: assert property (
    (rstn && ch3_mode == 4'h8) [*3] |-> pwm_out1_neg == !pwm_out1_pos
    && pwm_out2_neg == !pwm_out2_pos && pwm_out3_neg == !pwm_out3_pos)
    else $error("pwm pair not inverse");
endmodule
bind qcsp_top qcsp_checker u_chk (.*);

// ==== verification/qcsp_enc_model.sv ====
// two quadrature encoders turning in opposite senses
`timescale 1ns/1ps
module qcsp_enc_model (
  input wire core_clk,
  output wire ext_clock_in_a,
  output wire ext_clock_in_b,
  output wire ext_clock_in_c,
  output wire ext_clock_in_d
);
  // =====
  // gray sequence 00 10 11 01, one pin moves per step
  logic [1:0] pos1_reg = 2'h0;
  logic [1:0] pos2_reg = 2'h0;
  assign ext_clock_in_a = pos1_reg[0] ^ pos1_reg[1];
  assign ext_clock_in_b = pos1_reg[1];
  assign ext_clock_in_c = pos2_reg[0] ^ pos2_reg[1];
  assign ext_clock_in_d = pos2_reg[1];
  // quarter step off the falling edge, then dwell well past sync
  task automatic step(input logic fwd);
    @(negedge core_clk);
    pos1_reg += fwd ? 2'h1 : 2'h3;
    pos2_reg += fwd ? 2'h3 : 2'h1;
    repeat (5) @(negedge core_clk);
  endtask
endmodule

// ==== verification/qcsp_top_tb.sv ====
// self-checking bench for the quadrature count and pwm block
`timescale 1ns/1ps
module qcsp_top_tb;
  // =====
  // stimulus and observation signals
  logic core_clk = 1'b0, rstn = 1'b0, cnt_load = 1'b0;
  logic ch1_start = '0, ch2_start = '0, ch3_start = '0, ch4_start = '0;
  logic ch1_capture = '0, ch2_capture = '0;
  logic ch1_flag_clear = '0, ch2_flag_clear = '0;
  logic [3:0] ch1_mode = '0, ch2_mode = '0, ch3_mode = '0;
  logic [1:0] ch1_clear_sel = '0, ch2_clear_sel = '0;
  logic [15:0] ch1_gra = '0, ch1_grb = '0, ch2_gra = '0, ch2_grb = '0;
  logic [15:0] cnt_load_value = '0, ch3_period_reg = '0;
  logic [15:0] ch3_transition_reg = '0;
  logic [15:0] ch4_transition_reg_a = '0, ch4_transition_reg_b = '0;
  wire ext_clock_in_a, ext_clock_in_b, ext_clock_in_c, ext_clock_in_d;
  wire [15:0] ch1_count, ch2_count, ch3_counter, ch4_counter;
  wire [15:0] ch1_capture_value, ch2_capture_value;
  wire ch1_overflow_flag, ch1_underflow_flag, ch1_count_direction_flag;
  wire ch2_overflow_flag, ch2_underflow_flag, ch2_count_direction_flag;
  wire ch1_match_a, ch1_match_b, ch2_match_a, ch2_match_b;
  wire pwm_out1_pos, pwm_out1_neg, pwm_out2_pos, pwm_out2_neg;
  wire pwm_out3_pos, pwm_out3_neg;
  int err_total = 0;
  int cmp_count = 0;
  // counts per full turn and per a-phase wiggle, variants 1..4
  logic [15:0] fw [4] = '{16'h0004, 16'h0001, 16'h0001, 16'h0002};
  logic [15:0] wg [4] = '{16'h0000, 16'hFFFF, 16'h0000, 16'h0000};
  logic [15:0] h1, h2, h3;
  qcsp_top u_qcsp_top (.*);
  qcsp_enc_model u_qcsp_enc_model (.*);
  // free running clock
  initial forever #25 core_clk = ~core_clk;
  // helpers
  function automatic logic [15:0] b(input logic x);
    return {15'h0000, x};
  endfunction
  task automatic chk(input logic [15:0] got, e1, e2);
    cmp_count++;
    if (got !== e1 && got !== e2) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, e1);
    end
  endtask
  task automatic mv(input logic fwd, input int n);
    repeat (n) u_qcsp_enc_model.step(fwd);
  endtask
  task automatic load(input logic [15:0] v);
    cnt_load_value = v;
    cnt_load = 1'b1;
    @(negedge core_clk);
    cnt_load = 1'b0;
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    for (int m = 0; m < 4; m++) begin
      {ch1_start, ch2_start} = 2'b00;
      ch1_mode = 4'h4 + 4'(m);
      ch2_mode = ch1_mode;
      // A compare values that the counters will stand on at capture time, B values they will not
      ch1_gra = fw[m] - 16'h0001;
      ch1_grb = fw[m];
      ch2_gra = 16'hFFFF - fw[m];
      ch2_grb = fw[m];
      load(16'h0000);
      {ch1_start, ch2_start} = 2'b11;
      mv(1'b1, 1);
      mv(1'b0, 1);
      chk(ch1_count, wg[m], wg[m]);
      mv(1'b1, 4);
      chk(ch1_count, wg[m] + fw[m], wg[m] + fw[m]);
      chk(ch2_count, -fw[m], -fw[m]);
      mv(1'b0, 8);
      chk(ch1_count, wg[m] - fw[m], wg[m] - fw[m]);
      chk(b(ch1_underflow_flag), 16'h0001, 16'h0001);
      chk(b(ch1_count_direction_flag), 16'h0000, 16'h0000);
      chk(b(ch2_underflow_flag), 16'h0001, 16'h0001);
      chk(b(ch2_overflow_flag), 16'h0001, 16'h0001);
      chk(b(ch2_count_direction_flag), 16'h0001, 16'h0001);
      {ch1_start, ch2_start} = 2'b00;
      {ch1_flag_clear, ch2_flag_clear} = 2'b11;
      load(16'hFFFF);
      {ch1_flag_clear, ch2_flag_clear} = 2'b00;
      chk(b(ch1_underflow_flag), 16'h0000, 16'h0000);
      chk(b(ch2_overflow_flag), 16'h0000, 16'h0000);
      {ch1_start, ch2_start} = 2'b11;
      mv(1'b1, 4);
      chk(ch1_count, fw[m] - 16'h0001, fw[m] - 16'h0001);
      chk(b(ch1_overflow_flag), 16'h0001, 16'h0001);
      chk(b(ch1_count_direction_flag), 16'h0001, 16'h0001);
      chk(ch2_count, 16'hFFFF - fw[m], 16'hFFFF - fw[m]);
      chk(b(ch2_count_direction_flag), 16'h0000, 16'h0000);
      chk(b(ch1_match_a), 16'h0001, 16'h0001);
      chk(b(ch1_match_b), 16'h0000, 16'h0000);
      chk(b(ch2_match_a), 16'h0001, 16'h0001);
      chk(b(ch2_match_b), 16'h0000, 16'h0000);
      {ch1_capture, ch2_capture} = 2'b11;
      @(negedge core_clk);
      {ch1_capture, ch2_capture} = 2'b00;
      @(negedge core_clk);
      chk(ch1_capture_value, fw[m] - 16'h0001, fw[m] - 16'h0001);
      chk(ch2_capture_value, 16'hFFFF - fw[m], 16'hFFFF - fw[m]);
      ch1_start = 1'b0;
      mv(1'b1, 4);
      chk(ch1_count, fw[m] - 16'h0001, fw[m] - 16'h0001);
    end
    // clear on compare match while phase counting
    ch2_start = 1'b0;
    ch2_mode = 4'h4;
    ch2_clear_sel = 2'h1;
    ch2_gra = 16'hFFFE;
    load(16'h0000);
    ch2_start = 1'b1;
    mv(1'b1, 4);
    chk(ch2_count, 16'h0000, 16'h0000);
    // reset-synchronized pwm, period ten counts
    ch2_start = 1'b0;
    ch3_mode = 4'h8;
    ch3_period_reg = 16'h0009;
    ch3_transition_reg = 16'h0002;
    ch4_transition_reg_a = 16'h0003;
    ch4_transition_reg_b = 16'h0006;
    load(16'h0000);
    {ch3_start, ch4_start} = 2'b11;
    repeat (30) @(negedge core_clk);
    {h1, h2, h3} = '0;
    repeat (20) begin
      @(negedge core_clk);
      h1 += b(pwm_out1_pos);
      h2 += b(pwm_out2_pos);
      h3 += b(pwm_out3_pos);
    end
    chk(h1, 16'h000E, 16'h0006);
    chk(h2, 16'h000C, 16'h0008);
    chk(h3, 16'h0006, 16'h000E);
    // 55 clocks after start both counters stand at five
    repeat (5) @(negedge core_clk);
    chk(ch3_counter, 16'h0005, 16'h0005);
    chk(ch4_counter, 16'h0005, 16'h0005);
    chk(b(pwm_out1_neg), 16'h0000, 16'h0000);
    chk(b(pwm_out2_neg), 16'h0000, 16'h0000);
    chk(b(pwm_out3_neg), 16'h0001, 16'h0001);
    final_report();
  end
endmodule
